// file: core/qdc_pkg.sv
`default_nettype none

package qdc_pkg;

    // Command word layout.
    localparam int unsigned WORD_W      = 16;
    localparam int unsigned CHAN_N      = 4;
    localparam int unsigned SEL_W       = 2;
    localparam int unsigned SEL_HI_POS  = 15;
    localparam int unsigned SEL_LO_POS  = 14;
    localparam int unsigned PDN_POS     = 13;
    localparam int unsigned LDN_POS     = 12;
    localparam int unsigned CODE_MSB    = 11;
    localparam int unsigned BITCNT_W    = 5;
    localparam logic [4:0]  BITCNT_FULL = 5'h10;

    // Default converter resolution.
    localparam int unsigned RES_DEFAULT = 12;

    // Register bus map, byte addresses.
    localparam int unsigned ADDR_W      = 8;
    localparam logic [7:0]  OFF_CTRL    = 8'h00;
    localparam logic [7:0]  OFF_STATUS  = 8'h04;
    localparam logic [7:0]  OFF_INPUT0  = 8'h10;
    localparam logic [7:0]  OFF_DAC0    = 8'h20;
    localparam logic [7:0]  BLOCK_MASK  = 8'hf0;
    localparam logic [1:0]  WORD_ALIGN  = 2'h0;
    localparam int unsigned IDX_LSB     = 2;

    // Control and status fields.
    localparam int unsigned CTRL_EN_POS = 0;
    localparam logic        CTRL_EN_RST = 1'b1;
    localparam int unsigned ST_PD_POS   = 0;
    localparam int unsigned ST_CNT_LSB  = 8;
    localparam int unsigned FCNT_W      = 8;

    // Write and read responses.
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// file: core/qdc_channel.sv
`timescale 1ns/1ps
`default_nettype none

// One converter channel: the input register and the converter register behind it.
module qdc_channel #(
    parameter int unsigned CODE_W = 12
) (
    input  wire logic              mclk,
    input  wire logic              reset,
    input  wire logic              write_en,
    input  wire logic [CODE_W-1:0] code_in,
    input  wire logic              load_all,
    output logic      [CODE_W-1:0] input_code,
    output logic      [CODE_W-1:0] dac_code
);

    logic fresh_q;

    // The input register takes the code of a command addressed to this channel.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            input_code <= '0;
        end else if (write_en) begin
            input_code <= code_in;
        end
    end

    // Marks an input register changed since the last converter load.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            fresh_q <= 1'b0;
        end else if (write_en) begin
            fresh_q <= !load_all;
        end else if (load_all) begin
            fresh_q <= 1'b0;
        end
    end

    // The converter register loads only on load-all, and only with a changed input.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            dac_code <= '0;
        end else if (load_all && write_en) begin
            dac_code <= code_in;
        end else if (load_all && fresh_q) begin
            dac_code <= input_code;
        end
    end

endmodule

`default_nettype wire

// file: core/qdc_core.sv
`timescale 1ns/1ps
`default_nettype none

module qdc_core #(
    parameter int unsigned RES = qdc_pkg::RES_DEFAULT
) (
    input  wire logic                          mclk,
    input  wire logic                          reset,
    // Serial command link, clocked by the host.
    input  wire logic                          link_clk,
    input  wire logic                          frame_n,
    input  wire logic                          link_data,
    // Channel outputs.
    output logic [qdc_pkg::CHAN_N*RES-1:0]     dac_codes,
    output logic [qdc_pkg::CHAN_N-1:0]         out_enable,
    output logic                               powered_down,
    // AXI4-Lite register slave.
    input  wire logic [qdc_pkg::ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [qdc_pkg::ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready
);

    localparam int unsigned W = qdc_pkg::WORD_W;
    localparam int unsigned N = qdc_pkg::CHAN_N;

    // Only the three converter resolutions are served; any other width is refused.
    if (RES != 8 && RES != 10 && RES != 12) begin : g_bad_res
        $error("qdc_core: RES must be 8, 10 or 12");
    end

    // The select field must address exactly the channels that exist.
    if (N != 2 ** qdc_pkg::SEL_W) begin : g_bad_chan
        $error("qdc_core: CHAN_N does not match the select width");
    end

    // The bit counter must stop exactly at the end of a word.
    if (qdc_pkg::BITCNT_FULL != qdc_pkg::WORD_W) begin : g_bad_cnt
        $error("qdc_core: BITCNT_FULL does not match WORD_W");
    end

    // Link domain. These registers run on the falling edge of the host's clock,
    // which may stop between frames, so nothing here may wait for a later edge.
    // Only hold_q and done_tgl_q are read by the system clock.

    // Front-end shift state, whose shifter and bit counter are held cleared while the strobe is high.
    logic                         link_rst;
    logic [W-1:0]                 shift_q;
    logic [qdc_pkg::BITCNT_W-1:0] bitcnt_q;
    logic [W-1:0]                 shift_d;
    logic [W-1:0]                 hold_q;
    logic                         done_tgl_q;

    // A high frame strobe holds the front end cleared, so a short frame is lost.
    // The host parks its clock between frames, so the clear cannot wait for an edge.
    assign link_rst = reset | frame_n;

    // Next shift value, first bit ending up in bit fifteen.
    assign shift_d = {shift_q[W-2:0], link_data};

    // Shift register and bit counter; edges after the sixteenth are ignored.
    // The counter stays at sixteen until the strobe goes high and clears it.
    always_ff @(negedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            shift_q  <= '0;
            bitcnt_q <= '0;
        end else if (bitcnt_q != qdc_pkg::BITCNT_FULL) begin
            shift_q  <= shift_d;
            bitcnt_q <= bitcnt_q + 5'h01;
        end
    end

    // The completed word is held and announced by a toggle for the system clock.
    // The word is taken from the next shift value, so no later edge is needed.
    always_ff @(negedge link_clk or posedge reset) begin
        if (reset) begin
            hold_q     <= '0;
            done_tgl_q <= 1'b0;
        end else if (!frame_n && bitcnt_q == qdc_pkg::BITCNT_FULL - 5'h01) begin
            hold_q     <= shift_d;
            done_tgl_q <= !done_tgl_q;
        end
    end

    // System domain. A finished word is announced by a toggle, not a pulse, so
    // it survives the crossing however slow or fast the host's clock runs.

    // Crossing, command word and control state.
    logic       tgl_s1_q;
    logic       tgl_s2_q;
    logic       tgl_s3_q;
    logic       word_ev;
    logic [W-1:0] word_q;
    logic       word_valid_q;
    logic       link_en_q;
    logic       pd_q;
    logic [qdc_pkg::FCNT_W-1:0] fcnt_q;

    // Two flops bring the completion toggle across; the third finds its edge.
    // Nothing but the second flop reads the first.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_s3_q <= 1'b0;
        end else begin
            tgl_s1_q <= done_tgl_q;
            tgl_s2_q <= tgl_s1_q;
            tgl_s3_q <= tgl_s2_q;
        end
    end

    // One-cycle event for each word that the host completed.
    assign word_ev = tgl_s2_q ^ tgl_s3_q;

    // The held word is read only once the toggle has crossed, when it has long been
    // stable; it is never sampled while the host may still be changing it.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            word_q <= '0;
        end else if (word_ev) begin
            word_q <= hold_q;
        end
    end

    // A completed word is acted on only while the link is enabled.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            word_valid_q <= 1'b0;
        end else begin
            word_valid_q <= word_ev && link_en_q;
        end
    end

    // Fields of the accepted command word.
    logic [qdc_pkg::SEL_W-1:0] sel;
    logic                      pd_n;
    logic                      ld_n;
    logic [RES-1:0]            code;

    // Field split of the command word.
    assign sel  = {word_q[qdc_pkg::SEL_HI_POS], word_q[qdc_pkg::SEL_LO_POS]};
    assign pd_n = word_q[qdc_pkg::PDN_POS];
    assign ld_n = word_q[qdc_pkg::LDN_POS];
    assign code = word_q[qdc_pkg::CODE_MSB -: RES];

    // Power-down follows every accepted command; reset leaves normal operation.
    // The codes are kept while powered down; only the drive enables drop.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pd_q <= 1'b0;
        end else if (word_valid_q) begin
            pd_q <= !pd_n;
        end
    end

    // Count of accepted commands, for software.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            fcnt_q <= '0;
        end else if (word_valid_q) begin
            fcnt_q <= fcnt_q + 8'h01;
        end
    end

    // Codes of every channel, channel A in the lowest slice.
    logic [N*RES-1:0] input_codes;
    logic [N*RES-1:0] dac_int;

    // One channel register pair per output.
    for (genvar i = 0; i < N; i++) begin : g_chan
        qdc_channel #(
            .CODE_W (RES)
        ) u_chan (
            .mclk       (mclk),
            .reset      (reset),
            .write_en   (word_valid_q && sel == i[qdc_pkg::SEL_W-1:0]),
            .code_in    (code),
            .load_all   (word_valid_q && !ld_n),
            .input_code (input_codes[i*RES +: RES]),
            .dac_code   (dac_int[i*RES +: RES])
        );
    end

    // Outputs come from the converter registers alone and float in power-down.
    // A floating output is shown by its enable going low.
    assign dac_codes    = dac_int;
    assign out_enable   = {N{!pd_q}};
    assign powered_down = pd_q;

    // AXI4-Lite slave. Each write half is parked in its own register, so the
    // master may offer address and data in either order or together.

    // Write path state.
    logic                      aw_held_q;
    logic                      w_held_q;
    logic [qdc_pkg::ADDR_W-1:0] awaddr_q;
    logic [31:0]               wdata_q;
    logic [3:0]                wstrb_q;
    logic                      do_write;
    logic                      wr_hit;

    // A half is taken whenever none is parked; the write runs once both are in.
    assign s_axi_awready = !aw_held_q;
    assign s_axi_wready  = !w_held_q;
    assign do_write      = aw_held_q && w_held_q && !s_axi_bvalid;

    // Address and data are taken independently and held until the write is done.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            aw_held_q <= 1'b0;
            awaddr_q  <= '0;
        end else if (s_axi_awvalid && !aw_held_q) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
        end
    end

    // Write data and strobes, parked the same way as the address.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            w_held_q <= 1'b0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
        end else if (s_axi_wvalid && !w_held_q) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_q <= 1'b0;
        end
    end

    // Accepted write addresses: control, status and the code words; only control stores data, the others ignore it.
    assign wr_hit = awaddr_q == qdc_pkg::OFF_CTRL || awaddr_q == qdc_pkg::OFF_STATUS
                 || (awaddr_q & qdc_pkg::BLOCK_MASK) == qdc_pkg::OFF_INPUT0
                    && awaddr_q[qdc_pkg::IDX_LSB +: qdc_pkg::SEL_W] < N
                    && awaddr_q[qdc_pkg::IDX_LSB-1:0] == qdc_pkg::WORD_ALIGN
                 || (awaddr_q & qdc_pkg::BLOCK_MASK) == qdc_pkg::OFF_DAC0
                    && awaddr_q[qdc_pkg::IDX_LSB +: qdc_pkg::SEL_W] < N
                    && awaddr_q[qdc_pkg::IDX_LSB-1:0] == qdc_pkg::WORD_ALIGN;

    // Control register: link enable gates acceptance of completed commands.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            link_en_q <= qdc_pkg::CTRL_EN_RST;
        end else if (do_write && awaddr_q == qdc_pkg::OFF_CTRL && wstrb_q[0]) begin
            link_en_q <= wdata_q[qdc_pkg::CTRL_EN_POS];
        end
    end

    // Write response, one cycle after both halves are held.
    // No new write starts while the response waits, since do_write needs it low.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= qdc_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? qdc_pkg::RESP_OKAY : qdc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read path decode.
    logic [31:0] rd_data;
    logic        rd_hit;
    logic [1:0]  rd_idx;

    // A new address is taken only when no answer is waiting.
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_idx        = s_axi_araddr[qdc_pkg::IDX_LSB +: qdc_pkg::SEL_W];

    // Read decode; unmapped addresses return zero with an error response.
    always_comb begin
        rd_data = '0;
        rd_hit  = 1'b1;
        if (s_axi_araddr == qdc_pkg::OFF_CTRL) begin
            rd_data[qdc_pkg::CTRL_EN_POS] = link_en_q;
        end else if (s_axi_araddr == qdc_pkg::OFF_STATUS) begin
            rd_data[qdc_pkg::ST_PD_POS] = pd_q;
            rd_data[qdc_pkg::ST_CNT_LSB +: qdc_pkg::FCNT_W] = fcnt_q;
        end else if ((s_axi_araddr & qdc_pkg::BLOCK_MASK) == qdc_pkg::OFF_INPUT0
                     && s_axi_araddr[qdc_pkg::IDX_LSB-1:0] == qdc_pkg::WORD_ALIGN) begin
            rd_data[RES-1:0] = input_codes[rd_idx*RES +: RES];
        end else if ((s_axi_araddr & qdc_pkg::BLOCK_MASK) == qdc_pkg::OFF_DAC0
                     && s_axi_araddr[qdc_pkg::IDX_LSB-1:0] == qdc_pkg::WORD_ALIGN) begin
            rd_data[RES-1:0] = dac_int[rd_idx*RES +: RES];
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Read answer, registered one cycle after the address is taken.
    // The answer stands until rready, and no new address is taken meanwhile.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= qdc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_data;
            s_axi_rresp  <= rd_hit ? qdc_pkg::RESP_OKAY : qdc_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// file: verif/qdc_core_chk.sv
`timescale 1ns/1ps
`default_nettype none

// Watches the core's ports for reset state, output float and bus handshakes.
module qdc_core_chk #(
    parameter int unsigned RES = 12
) (
    input wire logic                             mclk,
    input wire logic                             reset,
    input wire logic                             frame_n,
    input wire logic [qdc_pkg::CHAN_N*RES-1:0]   dac_codes,
    input wire logic [qdc_pkg::CHAN_N-1:0]       out_enable,
    input wire logic                             powered_down,
    input wire logic                             s_axi_awvalid,
    input wire logic                             s_axi_awready,
    input wire logic                             s_axi_wvalid,
    input wire logic                             s_axi_wready,
    input wire logic                             s_axi_bvalid,
    input wire logic                             s_axi_bready,
    input wire logic                             s_axi_arvalid,
    input wire logic                             s_axi_arready,
    input wire logic                             s_axi_rvalid,
    input wire logic                             s_axi_rready
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    // Output relations and bus answers, each with its exact cycle figure.
    property p_reset_state;
        $fell(reset) |-> dac_codes == '0 && !powered_down && out_enable == 4'hf;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
    property p_pd_float;
        out_enable == {4{!powered_down}};
    endproperty
    a_pd_float: assert property (p_pd_float) else $error("enables disagree with power");
    property p_quiet_idle;
        frame_n [*8] |-> $stable(dac_codes) && $stable(powered_down);
    endproperty
    a_quiet_idle: assert property (p_quiet_idle) else $error("outputs moved without frame");
    property p_wr_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write response late");
    property p_wr_done;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_wr_done: assert property (p_wr_done) else $error("write response not cleared");
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read data late");
    property p_rd_done;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_rd_done: assert property (p_rd_done) else $error("read data not cleared");
    property p_rd_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_rd_block: assert property (p_rd_block) else $error("read taken while data pending");
endmodule

bind qdc_core qdc_core_chk #(.RES(RES)) chk_inst (
    .mclk(mclk), .reset(reset), .frame_n(frame_n), .dac_codes(dac_codes),
    .out_enable(out_enable), .powered_down(powered_down),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

`default_nettype wire

// file: verif/qdc_host.sv
`timescale 1ns/1ps
`default_nettype none

// Host serial controller that frames command words onto the three-wire link.
module qdc_host (
    output logic link_clk,
    output logic frame_n,
    output logic link_data
);
    // The link idles with its clock parked high and the strobe released.
    initial begin
        link_clk  = 1'b1;
        frame_n   = 1'b1;
        link_data = 1'b0;
    end

    // Sends the top nbits of a word; fewer than sixteen aborts the frame.
    task automatic send(input logic [15:0] word, input int nbits);
        #37 frame_n = 1'b0;
        for (int i = 15; i > 15 - nbits; i--) begin
            link_data = word[i];
            #80 link_clk = 1'b0;
            #80 link_clk = 1'b1;
        end
        frame_n   = 1'b1;
        link_data = ~link_data;
        #160;
    endtask
endmodule

`default_nettype wire

// file: verif/quad_dac_serial_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module quad_dac_serial_control_tb;
    localparam int RES = 12;
    logic               mclk, reset, link_clk, frame_n, link_data;
    logic [4*RES-1:0]   dac_codes;
    logic [3:0]         out_enable, s_axi_wstrb;
    logic               powered_down, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic               s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic               s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]         s_axi_awaddr, s_axi_araddr;
    logic [31:0]        s_axi_wdata, s_axi_rdata;
    logic [1:0]         s_axi_bresp, s_axi_rresp;
    int                 n_fail, checks;
    logic [15:0]        row_word [7] = '{16'h3abc, 16'h7123, 16'hb456, 16'he789,
                                         16'h0fff, 16'h6001, 16'hf000};
    logic [4*RES-1:0]   row_dac [7] = '{48'h0, 48'h0, 48'h0, 48'h789456123abc,
                                        48'h789456123fff, 48'h789456001fff, 48'h789456001fff};
    logic               row_pd [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

    qdc_core #(.RES(RES)) qdc_core_inst (
        .mclk(mclk), .reset(reset), .link_clk(link_clk), .frame_n(frame_n),
        .link_data(link_data), .dac_codes(dac_codes), .out_enable(out_enable),
        .powered_down(powered_down), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready)
    );
    qdc_host qdc_host_inst (.link_clk(link_clk), .frame_n(frame_n), .link_data(link_data));

    // Free-running system clock.
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Prints the verdict and stops the run.
    task automatic end_of_test();
        if (n_fail == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One register write; each channel is released when it is taken.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge mclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 50) begin
            n_fail++;
            end_of_test();
        end
    endtask

    // One register read, holding rready until the data arrives.
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge mclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 50) begin
            n_fail++;
            end_of_test();
        end
    endtask

    // Cuts a hung run short.
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        end_of_test();
    end

    // Main sequence: reset, the command table, then the awkward cases.
    initial begin
        logic [1:0]  rsp;
        logic [31:0] rd;
        n_fail = 0;
        checks = 0;
        reset <= 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
        s_axi_wstrb <= 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        repeat (2) @(posedge mclk);
        chk(dac_codes, '0);
        chk({powered_down, out_enable}, 5'h0f);
        for (int i = 0; i < 7; i++) begin
            qdc_host_inst.send(row_word[i], 16);
            repeat (10) @(posedge mclk);
            chk(dac_codes, row_dac[i]);
            chk({powered_down, out_enable}, {row_pd[i], {4{!row_pd[i]}}});
        end
        axi_rd(qdc_pkg::OFF_STATUS, rd, rsp);
        chk({rsp, rd}, {qdc_pkg::RESP_OKAY, 32'h0000_0700});
        axi_rd(qdc_pkg::OFF_INPUT0 + 8'h0c, rd, rsp);
        chk(rd, 32'h0);
        axi_rd(qdc_pkg::OFF_DAC0 + 8'h0c, rd, rsp);
        chk(rd, 32'h789);
        qdc_host_inst.send(16'h3555, 15);
        repeat (10) @(posedge mclk);
        chk(dac_codes, row_dac[6]);
        axi_rd(qdc_pkg::OFF_INPUT0, rd, rsp);
        chk(rd, 32'hfff);
        axi_wr(qdc_pkg::OFF_CTRL, 32'h0, rsp);
        chk(rsp, qdc_pkg::RESP_OKAY);
        qdc_host_inst.send(16'h2555, 16);
        repeat (10) @(posedge mclk);
        chk(dac_codes, row_dac[6]);
        axi_rd(qdc_pkg::OFF_STATUS, rd, rsp);
        chk({rsp, rd}, {qdc_pkg::RESP_OKAY, 32'h0000_0700});
        axi_wr(qdc_pkg::OFF_CTRL, 32'h1, rsp);
        chk(rsp, qdc_pkg::RESP_OKAY);
        axi_rd(8'h08, rd, rsp);
        chk({rsp, rd}, {qdc_pkg::RESP_SLVERR, 32'h0});
        axi_wr(8'h0c, 32'h0, rsp);
        chk(rsp, qdc_pkg::RESP_SLVERR);
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        repeat (2) @(posedge mclk);
        chk(dac_codes, '0);
        chk({powered_down, out_enable}, 5'h0f);
        axi_rd(qdc_pkg::OFF_INPUT0, rd, rsp);
        chk(rd, 32'h0);
        end_of_test();
    end
endmodule

`default_nettype wire
